// *** hw/rx_cell_port_pkg.sv ***
/*
 * Constants and carrier types for the receive cell port.
 * Assumes a byte-addressed register port with 32-bit data.
 */
package rx_cell_port_pkg;

    // register byte offsets
    localparam logic [7:0] PHY_ADDR_OFS = 8'h6c;
    localparam logic [7:0] CTRL_OFS     = 8'h70;
    localparam logic [7:0] STATUS_OFS   = 8'h74;

    // reset values
    localparam logic [7:0] PHY_ADDR_RST = 8'h00;
    localparam logic [3:0] CTRL_RST     = 4'h0;

    // control register field positions
    localparam int CTRL_UNI_BIT  = 0;
    localparam int CTRL_MPHY_BIT = 1;
    localparam int CTRL_CELL_BIT = 2;
    localparam int CTRL_WIDE_BIT = 3;

    localparam int PHY_ADDR_W = 5;
    localparam int DATA_W     = 16;

    // cell length in bus transfers for each bus width
    localparam int CELL_XFERS_8  = 53;
    localparam int CELL_XFERS_16 = 27;

    typedef struct packed {
        logic                  uni;
        logic                  multi_phy;
        logic                  cell_level;
        logic                  wide;
        logic [PHY_ADDR_W-1:0] phy_addr;
    } port_cfg_s;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } queue_push_s;

endpackage : rx_cell_port_pkg

// *** hw/utopia_rx_cell_port.sv ***
/*
 * Receive cell port: a dual-clock cell queue filled on clock and drained
 * onto the receive cell bus on rx_bus_clock, with start-of-cell, parity and
 * cell-available signalling, single or multi-PHY.
 * Assumes the select address and output enable are synchronous to
 * rx_bus_clock and that the upstream writer pushes whole cells, first word
 * first. Bus pins are resolved by the surroundings from the _oe_n outputs.
 */
// Behaviour
// - start-of-cell flag marks the first transfer of every cell on the bus.
// - select address sampled each bus clock edge, only in multi-PHY mode.
// - on address match, cell-available reports whether cells are waiting.
// - on mismatch, cell-available stays tri-stated; the data bus still drives and pops on enable low.
// - odd parity of each transfer is shown in the same cycle as the data.
// - octet handshake (single-PHY only): cell-available high while any queue data exists.
// - cell handshake: cell-available high only with a whole cell queued.
// - multi-PHY: cell-available tri-stated until the cycle after a match.
// - flag, parity and cell-available driven only in ATM UNI operation.
// - enable high tri-states the bus; enable low pops the front word next edge.
`timescale 1ns/1ps

module utopia_rx_cell_port #(
    parameter int QUEUE_AW = 9
) (
    input  wire logic                                   clock,
    input  wire logic                                   rst_n,
    input  wire logic [7:0]                             reg_addr,
    input  wire logic [31:0]                            reg_wdata,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output logic      [31:0]                            reg_rdata,
    input  wire rx_cell_port_pkg::queue_push_s          push_in,
    output logic                                        push_ready,
    input  wire logic                                   rx_bus_clock,
    input  wire logic [rx_cell_port_pkg::PHY_ADDR_W-1:0] rx_phy_select_addr,
    input  wire logic                                   rx_bus_output_enable_n,
    output logic      [rx_cell_port_pkg::DATA_W-1:0]    rx_cell_bus,
    output logic                                        rx_cell_bus_oe_n,
    output logic                                        rx_cell_start_flag,
    output logic                                        rx_bus_parity,
    output logic                                        rx_cell_available,
    output logic                                        rx_cell_available_oe_n
);

    localparam int PW = QUEUE_AW + 1;
    localparam logic [PW-1:0] DEPTH_V = {1'b1, {QUEUE_AW{1'b0}}};
    localparam logic [PW-1:0] CELL8_V = PW'(rx_cell_port_pkg::CELL_XFERS_8);
    localparam logic [PW-1:0] CELL16_V = PW'(rx_cell_port_pkg::CELL_XFERS_16);

    function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b = '0;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--) begin
            b[i] = g[i] ^ b[i+1];
        end
        return b;
    endfunction : gray2bin

    logic [rx_cell_port_pkg::DATA_W-1:0] mem [0:(1<<QUEUE_AW)-1];

    // system domain
    logic [7:0]    phy_addr_q;
    logic [3:0]    ctrl_q;
    logic [PW-1:0] wbin_q;
    logic [PW-1:0] wgray_q;
    logic [PW-1:0] rgray_q;
    logic [PW-1:0] rgray_meta_q;
    logic [PW-1:0] rgray_sync_q;
    logic [PW-1:0] wr_fill;
    logic          push_w;

    rx_cell_port_pkg::port_cfg_s cfg_sys;

    assign cfg_sys = '{uni:        ctrl_q[rx_cell_port_pkg::CTRL_UNI_BIT],
                       multi_phy:  ctrl_q[rx_cell_port_pkg::CTRL_MPHY_BIT],
                       cell_level: ctrl_q[rx_cell_port_pkg::CTRL_CELL_BIT],
                       wide:       ctrl_q[rx_cell_port_pkg::CTRL_WIDE_BIT],
                       phy_addr:   phy_addr_q[rx_cell_port_pkg::PHY_ADDR_W-1:0]};

    assign push_w  = push_in.valid && push_ready;
    assign wr_fill = wbin_q - gray2bin(rgray_sync_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phy_addr_q <= rx_cell_port_pkg::PHY_ADDR_RST;
            ctrl_q     <= rx_cell_port_pkg::CTRL_RST;
        end else if (reg_wr) begin
            if (reg_addr == rx_cell_port_pkg::PHY_ADDR_OFS) phy_addr_q <= reg_wdata[7:0];
            if (reg_addr == rx_cell_port_pkg::CTRL_OFS) ctrl_q <= reg_wdata[3:0];
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                rx_cell_port_pkg::PHY_ADDR_OFS: reg_rdata <= {24'h000000, phy_addr_q};
                rx_cell_port_pkg::CTRL_OFS:     reg_rdata <= {28'h0000000, ctrl_q};
                rx_cell_port_pkg::STATUS_OFS:   reg_rdata <= 32'(wr_fill);
                default:                        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    always_ff @(posedge clock) begin
        if (push_w) mem[wbin_q[QUEUE_AW-1:0]] <= push_in.data;
    end

    // ready is pessimistic by one read-pointer crossing, never optimistic
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wbin_q       <= '0;
            wgray_q      <= '0;
            rgray_meta_q <= '0;
            rgray_sync_q <= '0;
            push_ready   <= 1'b0;
        end else begin
            rgray_meta_q <= rgray_q;
            rgray_sync_q <= rgray_meta_q;
            wbin_q       <= wbin_q + PW'(push_w);
            wgray_q      <= bin2gray(wbin_q + PW'(push_w));
            push_ready   <= (wr_fill + PW'(push_w)) != DEPTH_V;
        end
    end

    // link domain
    logic [1:0]    link_rst_q;
    logic          link_rst_n;
    logic [PW-1:0] rbin_q;
    logic [PW-1:0] wgray_meta_q;
    logic [PW-1:0] wgray_sync_q;
    logic [PW-1:0] rd_fill;
    logic [PW-1:0] cell_len;
    logic [PW-1:0] word_idx_q;
    logic          pop_w;
    logic          addr_hit;

    logic [rx_cell_port_pkg::DATA_W-1:0] bus_d;

    rx_cell_port_pkg::port_cfg_s cfg_meta_q;
    rx_cell_port_pkg::port_cfg_s cfg_sync_q;
    rx_cell_port_pkg::port_cfg_s cfg_stab_q;
    rx_cell_port_pkg::port_cfg_s cfg_q;

    assign link_rst_n = link_rst_q[1];
    assign rd_fill    = gray2bin(wgray_sync_q) - rbin_q;
    assign cell_len   = cfg_q.wide ? CELL16_V : CELL8_V;
    assign pop_w      = cfg_q.uni && !rx_bus_output_enable_n && (rd_fill != '0);
    assign addr_hit   = rx_phy_select_addr == cfg_q.phy_addr;
    assign bus_d      = pop_w ? mem[rbin_q[QUEUE_AW-1:0]] : rx_cell_bus;

    // release of reset is synchronised to the bus clock, assertion is not
    always_ff @(posedge rx_bus_clock or negedge rst_n) begin
        if (!rst_n) link_rst_q <= 2'b00;
        else link_rst_q <= {link_rst_q[0], 1'b1};
    end

    // configuration is quasi-static; software changes it only while idle
    // bits may cross on different edges, so a setting is taken only once two samples agree
    always_ff @(posedge rx_bus_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            cfg_meta_q   <= '0;
            cfg_sync_q   <= '0;
            cfg_stab_q   <= '0;
            cfg_q        <= '0;
            wgray_meta_q <= '0;
            wgray_sync_q <= '0;
        end else begin
            cfg_meta_q   <= cfg_sys;
            cfg_sync_q   <= cfg_meta_q;
            cfg_stab_q   <= cfg_sync_q;
            if (cfg_sync_q == cfg_stab_q) cfg_q <= cfg_stab_q;
            wgray_meta_q <= wgray_q;
            wgray_sync_q <= wgray_meta_q;
        end
    end

    always_ff @(posedge rx_bus_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rbin_q     <= '0;
            rgray_q    <= '0;
            word_idx_q <= '0;
            rx_cell_bus <= '0;
        end else if (pop_w) begin
            rx_cell_bus <= mem[rbin_q[QUEUE_AW-1:0]];
            rbin_q      <= rbin_q + 1'b1;
            rgray_q     <= bin2gray(rbin_q + 1'b1);
            word_idx_q  <= (word_idx_q == cell_len - 1'b1) ? '0 : word_idx_q + 1'b1;
        end
    end

    always_ff @(posedge rx_bus_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_cell_bus_oe_n   <= 1'b1;
            rx_cell_start_flag <= 1'b0;
            rx_bus_parity      <= 1'b0;
        end else begin
            rx_cell_bus_oe_n   <= rx_bus_output_enable_n || !cfg_q.uni;
            rx_cell_start_flag <= pop_w && (word_idx_q == '0);
            // recomputed every edge so a held word never shows a stale or reset parity
            if (!cfg_q.uni) rx_bus_parity <= 1'b0;
            else rx_bus_parity <= cfg_q.wide ? ~^bus_d : ~^bus_d[7:0];
        end
    end

    always_ff @(posedge rx_bus_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rx_cell_available      <= 1'b0;
            rx_cell_available_oe_n <= 1'b1;
        end else if (!cfg_q.uni) begin
            rx_cell_available      <= 1'b0;
            rx_cell_available_oe_n <= 1'b1;
        end else if (cfg_q.multi_phy) begin
            rx_cell_available      <= rd_fill >= cell_len;
            rx_cell_available_oe_n <= !addr_hit;
        end else begin
            rx_cell_available      <= cfg_q.cell_level ? (rd_fill >= cell_len) : (rd_fill != '0);
            rx_cell_available_oe_n <= 1'b0;
        end
    end

    sequence s_hit;
        cfg_q.uni && cfg_q.multi_phy && addr_hit;
    endsequence

    sequence s_miss;
        cfg_q.uni && cfg_q.multi_phy && !addr_hit;
    endsequence

    property p_start_flag;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        rx_cell_start_flag |-> $past(pop_w) && ($past(word_idx_q) == '0) && !rx_cell_bus_oe_n;
    endproperty
    a_start_flag: assert property (p_start_flag) else $error("start flag without first word");

    property p_addr_ignored;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        (cfg_q.uni && !cfg_q.multi_phy) |=> !rx_cell_available_oe_n;
    endproperty
    a_addr_ignored: assert property (p_addr_ignored) else $error("single-PHY cell-available not driven");

    property p_hit_value;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        s_hit |=> rx_cell_available == ($past(rd_fill) >= $past(cell_len));
    endproperty
    a_hit_value: assert property (p_hit_value) else $error("matched cell-available wrong");

    property p_miss_float;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        s_miss |=> rx_cell_available_oe_n;
    endproperty
    a_miss_float: assert property (p_miss_float) else $error("cell-available driven on mismatch");

    property p_odd_parity;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        (!rx_cell_bus_oe_n && cfg_q.wide && $past(cfg_q.wide)) |-> ^{rx_cell_bus, rx_bus_parity};
    endproperty
    a_odd_parity: assert property (p_odd_parity) else $error("wide parity not odd");

    property p_narrow_parity;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        (!rx_cell_bus_oe_n && !cfg_q.wide && $past(!cfg_q.wide)) |-> ^{rx_cell_bus[7:0], rx_bus_parity};
    endproperty
    a_narrow_parity: assert property (p_narrow_parity) else $error("narrow parity not odd");

    property p_octet;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        (cfg_q.uni && !cfg_q.multi_phy && !cfg_q.cell_level) |=> rx_cell_available == ($past(rd_fill) != '0);
    endproperty
    a_octet: assert property (p_octet) else $error("octet cell-available wrong");

    property p_cell;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        (cfg_q.uni && !cfg_q.multi_phy && cfg_q.cell_level) |=>
            rx_cell_available == ($past(rd_fill) >= $past(cell_len));
    endproperty
    a_cell: assert property (p_cell) else $error("cell-level cell-available wrong");

    property p_float_until_hit;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        s_miss ##1 s_hit |-> rx_cell_available_oe_n ##1 !rx_cell_available_oe_n;
    endproperty
    a_float_until_hit: assert property (p_float_until_hit) else $error("multi-PHY drive timing wrong");

    property p_clear_channel;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        !cfg_q.uni |=> !rx_cell_start_flag && rx_cell_bus_oe_n && rx_cell_available_oe_n && !rx_bus_parity;
    endproperty
    a_clear_channel: assert property (p_clear_channel) else $error("outputs active in clear-channel");

    property p_pop;
        @(posedge rx_bus_clock) disable iff (!link_rst_n)
        rx_bus_output_enable_n |=> rx_cell_bus_oe_n && (rbin_q == $past(rbin_q));
    endproperty
    a_pop: assert property (p_pop) else $error("bus driven or popped while disabled");

endmodule : utopia_rx_cell_port

// *** testbench/atm_layer_model.sv ***
/*
 * ATM-side reader model: drives the select address and the output enable.
 * Assumes the bench calls read_words and set_addr by hierarchical name.
 */
`timescale 1ns/1ps

module atm_layer_model (
    input  wire logic                                    rx_bus_clock,
    output logic [rx_cell_port_pkg::PHY_ADDR_W-1:0]      rx_phy_select_addr,
    output logic                                         rx_bus_output_enable_n
);
    initial begin
        rx_phy_select_addr     = 5'h00;
        rx_bus_output_enable_n = 1'b1;
    end

    // slow reader leaves a high cycle between pops
    task automatic read_words(input int n, input bit slow);
        for (int i = 0; i < n; i++) begin
            @(posedge rx_bus_clock);
            rx_bus_output_enable_n <= 1'b0;
            if (slow) begin
                @(posedge rx_bus_clock);
                rx_bus_output_enable_n <= 1'b1;
            end
        end
        @(posedge rx_bus_clock);
        rx_bus_output_enable_n <= 1'b1;
    endtask : read_words

    // the new select address is driven from the next bus clock edge
    task automatic set_addr(input logic [4:0] a);
        @(posedge rx_bus_clock);
        rx_phy_select_addr <= a;
    endtask : set_addr
endmodule : atm_layer_model

// *** testbench/tb.sv ***
/*
 * Self-checking bench for the receive cell port.
 * Assumes the register map and control bits of rx_cell_port_pkg.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb;
    logic                           clock = 1'b0;
    logic                           rx_bus_clock = 1'b0;
    logic                           rst_n = 1'b0;
    logic [7:0]                     reg_addr;
    logic [31:0]                    reg_wdata, reg_rdata;
    logic                           reg_wr, reg_rd, push_ready;
    rx_cell_port_pkg::queue_push_s  push_in;
    logic [15:0]                    rx_cell_bus;
    logic                           rx_cell_bus_oe_n, rx_cell_start_flag, rx_bus_parity;
    logic                           rx_cell_available, rx_cell_available_oe_n, rx_bus_output_enable_n;
    logic [4:0]                     rx_phy_select_addr;
    int                             mismatches = 0, samples_checked = 0, len;
    logic [31:0]                    rq[$];
    logic [16:0]                    lq[$];
    logic [16:0]                    exp_q;
    logic                           rd_q = 1'b0, pop_q = 1'b0, wide_q = 1'b0;

    always #2.5 clock = ~clock;
    initial #1.1 forever #7.5 rx_bus_clock = ~rx_bus_clock;

    utopia_rx_cell_port #(.QUEUE_AW(6)) dut (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .push_in(push_in),
        .push_ready(push_ready), .rx_bus_clock(rx_bus_clock), .rx_phy_select_addr(rx_phy_select_addr),
        .rx_bus_output_enable_n(rx_bus_output_enable_n), .rx_cell_bus(rx_cell_bus),
        .rx_cell_bus_oe_n(rx_cell_bus_oe_n), .rx_cell_start_flag(rx_cell_start_flag),
        .rx_bus_parity(rx_bus_parity), .rx_cell_available(rx_cell_available),
        .rx_cell_available_oe_n(rx_cell_available_oe_n));

    atm_layer_model atm (
        .rx_bus_clock(rx_bus_clock), .rx_phy_select_addr(rx_phy_select_addr),
        .rx_bus_output_enable_n(rx_bus_output_enable_n));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic reg_wr_t(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : reg_wr_t

    task automatic reg_rd_t(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        rq.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
    endtask : reg_rd_t

    task automatic push_range(input int from, input int to);
        logic [15:0] d;
        int          n;
        for (int i = from; i < to; i++) begin
            d = 16'($urandom);
            lq.push_back({i == 0, d});
            @(posedge clock);
            push_in <= '{valid: 1'b1, data: d};
            n = 0;
            do begin
                @(posedge clock);
                n++;
            end while (push_ready !== 1'b1 && n < 100);
            if (n >= 100) begin
                mismatches++;
                stop_test();
            end
            push_in.valid <= 1'b0;
        end
    endtask : push_range

    task automatic waitl(input int n);
        repeat (n) @(posedge rx_bus_clock);
    endtask : waitl

    always @(posedge clock) begin
        if (rd_q && rq.size() > 0) begin
            `CHK(reg_rdata, rq.pop_front())
        end
        rd_q = (reg_rd === 1'b1);
    end

    // a pop sampled at one link edge shows its word from that edge on and is checked at the next one
    always @(posedge rx_bus_clock) begin
        if (pop_q && lq.size() > 0) begin
            exp_q = lq.pop_front();
            `CHK(rx_cell_bus, exp_q[15:0])
            `CHK(rx_cell_start_flag, exp_q[16])
            `CHK(rx_bus_parity, wide_q ? ~^exp_q[15:0] : ~^exp_q[7:0])
            `CHK(rx_cell_bus_oe_n, 1'b0)
        end
        pop_q = (rx_bus_output_enable_n === 1'b0);
    end

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        push_in   = '0;
        void'($urandom(40));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        reg_rd_t(rx_cell_port_pkg::PHY_ADDR_OFS, {24'h0, rx_cell_port_pkg::PHY_ADDR_RST});
        reg_rd_t(rx_cell_port_pkg::CTRL_OFS, 32'h0);
        reg_rd_t(8'h00, 32'h0);
        reg_wr_t(rx_cell_port_pkg::PHY_ADDR_OFS, 32'h0000000b);
        reg_rd_t(rx_cell_port_pkg::PHY_ADDR_OFS, 32'h0000000b);
        waitl(6);
        `CHK(rx_cell_available_oe_n, 1'b1)
        `CHK(rx_cell_start_flag, 1'b0)
        $display("test registers done");
        for (int w = 0; w < 2; w++) begin
            len    = w ? 27 : 53;
            wide_q = w[0];
            // narrow octet mode first, then wide cell mode
            reg_wr_t(rx_cell_port_pkg::CTRL_OFS, w ? 32'hd : 32'h1);
            atm.set_addr(5'($urandom));
            waitl(6);
            push_range(0, 1);
            waitl(8);
            `CHK(rx_cell_available_oe_n, 1'b0)
            `CHK(rx_cell_available, w ? 1'b0 : 1'b1)
            push_range(1, len - 1);
            waitl(8);
            `CHK(rx_cell_available, w ? 1'b0 : 1'b1)
            push_range(len - 1, len);
            waitl(8);
            `CHK(rx_cell_available, 1'b1)
            reg_rd_t(rx_cell_port_pkg::STATUS_OFS, 32'(len));
            atm.read_words(len, w == 0);
            waitl(8);
            `CHK(rx_cell_available, 1'b0)
            `CHK(rx_cell_bus_oe_n, 1'b1)
            $display("test cell pass %0d done", w);
        end
        reg_wr_t(rx_cell_port_pkg::CTRL_OFS, 32'hf);
        atm.set_addr(5'h04);
        waitl(6);
        push_range(0, 27);
        waitl(8);
        `CHK(rx_cell_available_oe_n, 1'b1)
        atm.set_addr(5'h0b);
        waitl(3);
        `CHK(rx_cell_available_oe_n, 1'b0)
        `CHK(rx_cell_available, 1'b1)
        atm.read_words(27, 1'b0);
        waitl(8);
        `CHK(rx_cell_available, 1'b0)
        atm.set_addr(5'h00);
        reg_wr_t(rx_cell_port_pkg::CTRL_OFS, 32'h0);
        waitl(6);
        `CHK(rx_cell_available_oe_n, 1'b1)
        $display("test multi-phy done");
        stop_test();
    end
endmodule : tb
